// [common/imu_cmd_consts.svh]
`ifndef IMU_CMD_CONSTS_SVH
`define IMU_CMD_CONSTS_SVH

// command identifiers
`define ID_ACK 8'h00
`define ID_NACK 8'h01
`define ID_FW_UPLOAD 8'h02
`define ID_LOADER_UPLOAD 8'h03
`define ID_GET_CONFIG 8'h04
`define ID_GET_STATUS 8'h05
`define ID_ENTER_COMMAND 8'h06
`define ID_ENTER_STREAMING 8'h07
`define ID_SET_TRANSMIT 8'h0a
`define ID_SET_OUTPUT_RATE 8'h0b
`define ID_SET_GYR_AUTOCAL 8'h17
`define ID_SET_GYR_THRES 8'h18
`define ID_SET_DATA_MODE 8'h4b

// upload chunk
`define CHUNK_LAST 9'h0ff

// enable bit of the one-bit set commands
`define SET_FLAG_BIT 0

// output rate values and their codes
`define RATE_5 32'h0000_0005
`define RATE_10 32'h0000_000a
`define RATE_30 32'h0000_001e
`define RATE_50 32'h0000_0032
`define RATE_100 32'h0000_0064
`define RATE_200 32'h0000_00c8
`define RATE_300 32'h0000_012c
`define RATE_500 32'h0000_01f4
`define RATE_CODE_RESET 3'h4

// configuration word fields
`define CFG_RATE_MSB 2
`define CFG_RATE_LSB 0
`define CFG_TXLO_MSB 14
`define CFG_TXLO_LSB 9
`define CFG_TXHI_MSB 19
`define CFG_TXHI_LSB 16
`define CFG_DYN_MAG 20
`define CFG_LIN_ACC 21
`define CFG_MODE16 22
`define CFG_GYR_THRES 23
`define CFG_MAG_COMP 24
`define CFG_ACC_COMP 25
`define CFG_GYR_AUTOCAL 30
`define CFG_RSVD_MASK 32'hbc00_81f8

// status word fields
`define STS_CMD_MODE 0
`define STS_STREAM_MODE 1
`define STS_GYR_CAL 3
`define STS_INIT_MSB 8
`define STS_INIT_LSB 5
`define STS_UNRESP_MSB 11
`define STS_UNRESP_LSB 9
`define STS_FLASH_FAIL 12
`define STS_RATE_FAIL 14
`define STS_RSVD_MASK 32'hffff_a014

`endif

// [common/imu_cmd_pkg.sv]
package imu_cmd_pkg;
    typedef enum logic {MODE_COMMAND, MODE_STREAM} op_mode_t;
    typedef enum logic {ST_IDLE, ST_CHUNK} cmd_state_t;
    typedef logic [7:0] cmd_id_t;
    typedef logic [31:0] word_t;
endpackage

// [src/chunk_byte_counter.sv]
`timescale 1ns/1ns
`include "imu_cmd_consts.svh"

module chunk_byte_counter (
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    input wire logic start,
    input wire logic byte_take,
    output logic last_byte
);
    logic [8:0] count_ff;
    logic [8:0] nxt_count;

    // counts bytes of one update packet
    always_comb begin
        nxt_count = count_ff;
        if (start) begin
            nxt_count = '0;
        end else if (byte_take) begin
            nxt_count = count_ff + 9'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign last_byte = byte_take && (count_ff == `CHUNK_LAST);
endmodule

// [src/imu_command_config_status.sv]
// What this block does
// - successful set command answered with id 0
// - failed set command answered with id 1
// - every update packet gets its own reply
// - id 4 returns read-only configuration word
// - config bits 0-2 show output rate
// - config bits 9-14 show sensor output enables
// - config bits 16-19, 21 show derived outputs
// - config bits 20, 24, 25 show corrections
// - config bits 22, 23, 30 show modes
// - id 5 returns read-only status word
// - status bits 0, 1, 3 show modes, calibration
// - status bits 5-8 flag initialization failures
// - status bits 9-12, 14 flag faults
// - id 6 enters command mode, replies
// - id 7 streams; refuses all but id 6
`timescale 1ns/1ns
`include "imu_cmd_consts.svh"

module imu_command_config_status (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_id,
    input wire logic [31:0] cmd_data,
    output logic cmd_ready,
    input wire logic pay_valid,
    input wire logic [7:0] pay_byte,
    input wire logic img_err,
    output logic img_valid,
    output logic [7:0] img_byte,
    output logic img_loader,
    output logic reply_valid,
    output logic [7:0] reply_id,
    output logic reply_has_data,
    output logic [31:0] reply_data,
    output logic stream_on,
    input wire logic dyn_mag_corr_en,
    input wire logic mag_comp_en,
    input wire logic acc_comp_en,
    input wire logic gyr_cal_active,
    input wire logic [3:0] init_fail,
    input wire logic [2:0] sensor_unresp,
    input wire logic flash_write_fail
);
    logic rst_meta_ff;
    logic rst_sync_n;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_n <= rst_meta_ff;
        end
    end

    function automatic logic [3:0] rate_code(input logic [31:0] val);
        case (val)
            `RATE_5: rate_code = {1'b1, 3'h0};
            `RATE_10: rate_code = {1'b1, 3'h1};
            `RATE_30: rate_code = {1'b1, 3'h2};
            `RATE_50: rate_code = {1'b1, 3'h3};
            `RATE_100: rate_code = {1'b1, 3'h4};
            `RATE_200: rate_code = {1'b1, 3'h5};
            `RATE_300: rate_code = {1'b1, 3'h6};
            `RATE_500: rate_code = {1'b1, 3'h7};
            default: rate_code = {1'b0, 3'h0};
        endcase
    endfunction

    imu_cmd_pkg::op_mode_t mode_ff, nxt_mode;
    imu_cmd_pkg::cmd_state_t state_ff, nxt_state;
    logic loader_ff, nxt_loader;
    logic [2:0] rate_ff, nxt_rate;
    logic [5:0] txlo_ff, nxt_txlo;
    logic [3:0] txhi_ff, nxt_txhi;
    logic lin_ff, nxt_lin;
    logic mode16_ff, nxt_mode16;
    logic thres_ff, nxt_thres;
    logic autocal_ff, nxt_autocal;
    logic rate_fail_ff, nxt_rate_fail;
    logic reply_valid_ff, nxt_reply_valid;
    logic [7:0] reply_id_ff, nxt_reply_id;
    logic reply_has_data_ff, nxt_reply_has_data;
    logic [31:0] reply_data_ff, nxt_reply_data;
    logic cmd_ready_ff, nxt_cmd_ready;
    logic img_valid_ff, nxt_img_valid;
    logic [7:0] img_byte_ff, nxt_img_byte;
    logic stream_on_ff, nxt_stream_on;
    logic [31:0] cfg_word;
    logic [31:0] status_word;
    logic take;
    logic byte_take;
    logic last_byte;
    logic [3:0] rate_dec;

    assign take = cmd_valid && cmd_ready_ff;
    assign byte_take = pay_valid && (state_ff == imu_cmd_pkg::ST_CHUNK);
    assign rate_dec = rate_code(cmd_data);

    chunk_byte_counter u_chunk (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .start(take),
        .byte_take(byte_take),
        .last_byte(last_byte)
    );

    // configuration word, reserved bits zero
    always_comb begin
        cfg_word = '0;
        cfg_word[`CFG_RATE_MSB:`CFG_RATE_LSB] = rate_ff;
        cfg_word[`CFG_TXLO_MSB:`CFG_TXLO_LSB] = txlo_ff;
        cfg_word[`CFG_TXHI_MSB:`CFG_TXHI_LSB] = txhi_ff;
        cfg_word[`CFG_LIN_ACC] = lin_ff;
        cfg_word[`CFG_DYN_MAG] = dyn_mag_corr_en;
        cfg_word[`CFG_MAG_COMP] = mag_comp_en;
        cfg_word[`CFG_ACC_COMP] = acc_comp_en;
        cfg_word[`CFG_MODE16] = mode16_ff;
        cfg_word[`CFG_GYR_THRES] = thres_ff;
        cfg_word[`CFG_GYR_AUTOCAL] = autocal_ff;
    end

    // status word, reserved bits zero
    always_comb begin
        status_word = '0;
        status_word[`STS_CMD_MODE] = (mode_ff == imu_cmd_pkg::MODE_COMMAND);
        status_word[`STS_STREAM_MODE] = (mode_ff == imu_cmd_pkg::MODE_STREAM);
        status_word[`STS_GYR_CAL] = gyr_cal_active;
        status_word[`STS_INIT_MSB:`STS_INIT_LSB] = init_fail;
        status_word[`STS_UNRESP_MSB:`STS_UNRESP_LSB] = sensor_unresp;
        status_word[`STS_FLASH_FAIL] = flash_write_fail;
        status_word[`STS_RATE_FAIL] = rate_fail_ff;
    end

    // command decode and reply
    always_comb begin
        nxt_mode = mode_ff;
        nxt_state = state_ff;
        nxt_loader = loader_ff;
        nxt_rate = rate_ff;
        nxt_txlo = txlo_ff;
        nxt_txhi = txhi_ff;
        nxt_lin = lin_ff;
        nxt_mode16 = mode16_ff;
        nxt_thres = thres_ff;
        nxt_autocal = autocal_ff;
        nxt_rate_fail = rate_fail_ff;
        nxt_reply_valid = 1'b0;
        nxt_reply_id = reply_id_ff;
        nxt_reply_has_data = 1'b0;
        nxt_reply_data = '0;
        nxt_img_valid = byte_take;
        nxt_img_byte = byte_take ? pay_byte : img_byte_ff;
        case (state_ff)
            imu_cmd_pkg::ST_IDLE: begin
                if (take) begin
                    nxt_reply_valid = 1'b1;
                    nxt_reply_id = `ID_ACK;
                    if (mode_ff == imu_cmd_pkg::MODE_STREAM) begin
                        if (cmd_id == `ID_ENTER_COMMAND) begin
                            nxt_mode = imu_cmd_pkg::MODE_COMMAND;
                        end else begin
                            nxt_reply_id = `ID_NACK;
                        end
                    end else begin
                        case (cmd_id)
                            `ID_FW_UPLOAD, `ID_LOADER_UPLOAD: begin
                                nxt_reply_valid = 1'b0;
                                nxt_state = imu_cmd_pkg::ST_CHUNK;
                                nxt_loader = (cmd_id == `ID_LOADER_UPLOAD);
                            end
                            `ID_GET_CONFIG: begin
                                nxt_reply_id = cmd_id;
                                nxt_reply_has_data = 1'b1;
                                nxt_reply_data = cfg_word;
                            end
                            `ID_GET_STATUS: begin
                                nxt_reply_id = cmd_id;
                                nxt_reply_has_data = 1'b1;
                                nxt_reply_data = status_word;
                            end
                            `ID_ENTER_COMMAND: begin
                                nxt_mode = imu_cmd_pkg::MODE_COMMAND;
                            end
                            `ID_ENTER_STREAMING: begin
                                nxt_mode = imu_cmd_pkg::MODE_STREAM;
                            end
                            `ID_SET_TRANSMIT: begin
                                nxt_txlo = cmd_data[`CFG_TXLO_MSB:`CFG_TXLO_LSB];
                                nxt_txhi = cmd_data[`CFG_TXHI_MSB:`CFG_TXHI_LSB];
                                nxt_lin = cmd_data[`CFG_LIN_ACC];
                            end
                            `ID_SET_OUTPUT_RATE: begin
                                nxt_rate_fail = !rate_dec[3];
                                if (rate_dec[3]) begin
                                    nxt_rate = rate_dec[2:0];
                                end else begin
                                    nxt_reply_id = `ID_NACK;
                                end
                            end
                            `ID_SET_GYR_AUTOCAL: nxt_autocal = cmd_data[`SET_FLAG_BIT];
                            `ID_SET_GYR_THRES: nxt_thres = cmd_data[`SET_FLAG_BIT];
                            `ID_SET_DATA_MODE: nxt_mode16 = cmd_data[`SET_FLAG_BIT];
                            default: nxt_reply_id = `ID_NACK;
                        endcase
                    end
                end
            end
            imu_cmd_pkg::ST_CHUNK: begin
                if (last_byte) begin
                    nxt_state = imu_cmd_pkg::ST_IDLE;
                    nxt_reply_valid = 1'b1;
                    nxt_reply_id = img_err ? `ID_NACK : `ID_ACK;
                end
            end
            default: nxt_state = imu_cmd_pkg::ST_IDLE;
        endcase
        nxt_cmd_ready = (nxt_state == imu_cmd_pkg::ST_IDLE);
        nxt_stream_on = (nxt_mode == imu_cmd_pkg::MODE_STREAM);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_ff <= imu_cmd_pkg::MODE_COMMAND;
            state_ff <= imu_cmd_pkg::ST_IDLE;
            loader_ff <= 1'b0;
            rate_ff <= `RATE_CODE_RESET;
            txlo_ff <= '0;
            txhi_ff <= '0;
            lin_ff <= 1'b0;
            mode16_ff <= 1'b0;
            thres_ff <= 1'b0;
            autocal_ff <= 1'b0;
            rate_fail_ff <= 1'b0;
            reply_valid_ff <= 1'b0;
            reply_id_ff <= `ID_ACK;
            reply_has_data_ff <= 1'b0;
            reply_data_ff <= '0;
            cmd_ready_ff <= 1'b0;
            img_valid_ff <= 1'b0;
            img_byte_ff <= '0;
            stream_on_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            state_ff <= nxt_state;
            loader_ff <= nxt_loader;
            rate_ff <= nxt_rate;
            txlo_ff <= nxt_txlo;
            txhi_ff <= nxt_txhi;
            lin_ff <= nxt_lin;
            mode16_ff <= nxt_mode16;
            thres_ff <= nxt_thres;
            autocal_ff <= nxt_autocal;
            rate_fail_ff <= nxt_rate_fail;
            reply_valid_ff <= nxt_reply_valid;
            reply_id_ff <= nxt_reply_id;
            reply_has_data_ff <= nxt_reply_has_data;
            reply_data_ff <= nxt_reply_data;
            cmd_ready_ff <= nxt_cmd_ready;
            img_valid_ff <= nxt_img_valid;
            img_byte_ff <= nxt_img_byte;
            stream_on_ff <= nxt_stream_on;
        end
    end

    assign cmd_ready = cmd_ready_ff;
    assign img_valid = img_valid_ff;
    assign img_byte = img_byte_ff;
    assign img_loader = loader_ff;
    assign reply_valid = reply_valid_ff;
    assign reply_id = reply_id_ff;
    assign reply_has_data = reply_has_data_ff;
    assign reply_data = reply_data_ff;
    assign stream_on = stream_on_ff;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_take_in_cmd(logic [7:0] id);
        take && cmd_id == id && !stream_on_ff;
    endsequence

    sequence s_reply(logic [7:0] id);
        reply_valid && reply_id == id;
    endsequence

    property p_set_ack;
        s_take_in_cmd(`ID_SET_OUTPUT_RATE) ##0 rate_dec[3] |=>
            s_reply(`ID_ACK) ##0 rate_ff == $past(rate_dec[2:0]);
    endproperty
    a_set_ack: assert property (p_set_ack) else $error("set rate not acked");
    property p_set_nack;
        s_take_in_cmd(`ID_SET_OUTPUT_RATE) ##0 !rate_dec[3] |=>
            s_reply(`ID_NACK) ##0 status_word[`STS_RATE_FAIL];
    endproperty
    a_set_nack: assert property (p_set_nack) else $error("bad rate not nacked");
    // a command taken in the cycle the chunk reply is out may reply right behind it
    property p_chunk_reply;
        (state_ff == imu_cmd_pkg::ST_CHUNK) ##0 last_byte |=>
            reply_valid && (reply_id == `ID_ACK || reply_id == `ID_NACK) ##1
            (!reply_valid || $past(take));
    endproperty
    a_chunk_reply: assert property (p_chunk_reply) else $error("chunk reply missing");
    property p_get_config;
        s_take_in_cmd(`ID_GET_CONFIG) |=>
            s_reply(`ID_GET_CONFIG) ##0 reply_data == $past(cfg_word);
    endproperty
    a_get_config: assert property (p_get_config) else $error("config word reply wrong");
    property p_get_status;
        s_take_in_cmd(`ID_GET_STATUS) |=>
            s_reply(`ID_GET_STATUS) ##0 reply_data == $past(status_word);
    endproperty
    a_get_status: assert property (p_get_status) else $error("status word reply wrong");
    property p_enter_command;
        take && cmd_id == `ID_ENTER_COMMAND |=>
            s_reply(`ID_ACK) ##0 !stream_on && status_word[`STS_CMD_MODE];
    endproperty
    a_enter_command: assert property (p_enter_command) else $error("command mode not entered");
    // pin-fed config bits may move while streaming, set fields may not
    property p_stream_refuse;
        take && stream_on_ff && cmd_id != `ID_ENTER_COMMAND |=>
            s_reply(`ID_NACK) ##0 stream_on && status_word[`STS_STREAM_MODE] ##0
            $stable({rate_ff, txlo_ff, txhi_ff, lin_ff, mode16_ff, thres_ff, autocal_ff});
    endproperty
    a_stream_refuse: assert property (p_stream_refuse) else $error("stream mode took a command");
    property p_reserved_zero;
        (cfg_word & `CFG_RSVD_MASK) == '0 && (status_word & `STS_RSVD_MASK) == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
endmodule

// [sim/host_model.sv]
`timescale 1ns/1ns

module host_model (
    input wire logic sys_clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output logic [7:0] cmd_id,
    output logic [31:0] cmd_data,
    output logic pay_valid,
    output logic [7:0] pay_byte,
    output logic hang
);
    initial begin
        cmd_valid = 1'b0;
        cmd_id = 8'hff;
        cmd_data = 32'hffff_ffff;
        pay_valid = 1'b0;
        pay_byte = 8'h5a;
        hang = 1'b0;
    end

    // command held until taken, then released with inverted lines
    task automatic send_cmd(input logic [7:0] id, input logic [31:0] data);
        int n;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_id = id;
        cmd_data = data;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (cmd_ready === 1'b1) break;
        end
        if (n == 50) hang = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd_id = ~id;
        cmd_data = ~data;
    endtask

    // one 256-byte chunk per packet, optional pause between bytes
    task automatic send_chunk(input int gap);
        for (int i = 0; i < 256; i++) begin
            @(negedge sys_clk);
            pay_valid = 1'b1;
            pay_byte = i[7:0];
            if (i < 255) begin
                repeat (gap) begin
                    @(negedge sys_clk);
                    pay_valid = 1'b0;
                    pay_byte = ~pay_byte;
                end
            end
        end
        // reply is already valid when this returns; caller checks it at once
        @(negedge sys_clk);
        pay_valid = 1'b0;
        pay_byte = 8'h00;
    endtask
endmodule

// [sim/tb_imu_command_config_status.sv]
`timescale 1ns/1ns

module tb_imu_command_config_status;
    logic sys_clk, rst_n, cmd_valid, cmd_ready, pay_valid, img_err, img_valid, img_loader;
    logic reply_valid, reply_has_data, stream_on, dyn_mag_corr_en, mag_comp_en, acc_comp_en;
    logic gyr_cal_active, flash_write_fail, hang;
    logic [7:0] cmd_id, pay_byte, img_byte, reply_id;
    logic [31:0] cmd_data, reply_data, cfg_exp;
    logic [3:0] init_fail;
    logic [2:0] sensor_unresp;
    int bad_count, cmp_count, img_count;
    logic [31:0] rates [8] = '{32'h5, 32'ha, 32'h1e, 32'h32, 32'h64, 32'hc8, 32'h12c, 32'h1f4};
    logic [7:0] flag_ids [3] = '{8'h17, 8'h18, 8'h4b};
    int flag_pos [3] = '{30, 23, 22};

    imu_command_config_status DUT (
        .sys_clk, .rst_n, .cmd_valid, .cmd_id, .cmd_data, .cmd_ready, .pay_valid,
        .pay_byte, .img_err, .img_valid, .img_byte, .img_loader, .reply_valid,
        .reply_id, .reply_has_data, .reply_data, .stream_on, .dyn_mag_corr_en,
        .mag_comp_en, .acc_comp_en, .gyr_cal_active, .init_fail, .sensor_unresp,
        .flash_write_fail
    );

    host_model host (
        .sys_clk, .cmd_ready, .cmd_valid, .cmd_id, .cmd_data, .pay_valid,
        .pay_byte, .hang
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // reply seen in the cycle right after the take edge
    task automatic do_cmd(input logic [7:0] id, input logic [31:0] data,
                          input logic [7:0] exp_id, input logic [31:0] exp_data);
        host.send_cmd(id, data);
        check(reply_valid, 32'h1);
        check(reply_id, exp_id);
        check(reply_has_data, exp_id == 8'h04 || exp_id == 8'h05);
        check(reply_data, exp_data);
    endtask

    task automatic get(input logic [7:0] id, input logic [31:0] exp);
        do_cmd(id, 32'h0, id, exp);
    endtask

    task automatic upload(input logic [7:0] id, input int gap, input logic err,
                          input logic [7:0] exp_id);
        img_err = err;
        host.send_cmd(id, 32'h0);
        check(reply_valid, 32'h0);
        check(cmd_ready, 32'h0);
        host.send_chunk(gap);
        check(reply_valid, 32'h1);
        check(reply_id, exp_id);
        check(img_loader, id == 8'h03);
    endtask

    always @(posedge sys_clk) begin
        if (img_valid === 1'b1) begin
            check(img_byte, img_count[7:0]);
            img_count++;
        end
    end

    always @(posedge sys_clk) begin
        if (hang === 1'b1) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        img_err = 1'b0;
        dyn_mag_corr_en = 1'b0;
        mag_comp_en = 1'b0;
        acc_comp_en = 1'b0;
        gyr_cal_active = 1'b0;
        init_fail = 4'h0;
        sensor_unresp = 3'h0;
        flash_write_fail = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        img_count = 0;
        cfg_exp = 32'h0000_0004;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        get(8'h04, cfg_exp);
        get(8'h05, 32'h0000_0001);
        do_cmd(8'h06, 32'h0, 8'h00, 32'h0);
        for (int k = 0; k < 8; k++) begin
            do_cmd(8'h0b, rates[k], 8'h00, 32'h0);
            cfg_exp[2:0] = k[2:0];
            get(8'h04, cfg_exp);
        end
        do_cmd(8'h0b, 32'h7, 8'h01, 32'h0);
        get(8'h05, 32'h0000_4001);
        get(8'h04, cfg_exp);
        do_cmd(8'h0b, 32'h64, 8'h00, 32'h0);
        cfg_exp[2:0] = 3'h4;
        get(8'h05, 32'h0000_0001);
        do_cmd(8'h63, 32'h0, 8'h01, 32'h0);
        do_cmd(8'h0a, 32'hffff_ffff, 8'h00, 32'h0);
        cfg_exp = cfg_exp | 32'h002f_7e00;
        get(8'h04, cfg_exp);
        for (int k = 0; k < 3; k++) begin
            do_cmd(flag_ids[k], 32'h1, 8'h00, 32'h0);
            cfg_exp[flag_pos[k]] = 1'b1;
            get(8'h04, cfg_exp);
        end
        do_cmd(8'h17, 32'h0, 8'h00, 32'h0);
        cfg_exp[30] = 1'b0;
        get(8'h04, cfg_exp);
        dyn_mag_corr_en = 1'b1;
        mag_comp_en = 1'b1;
        acc_comp_en = 1'b1;
        cfg_exp = cfg_exp | 32'h0310_0000;
        get(8'h04, cfg_exp);
        gyr_cal_active = 1'b1;
        init_fail = 4'hf;
        sensor_unresp = 3'h7;
        flash_write_fail = 1'b1;
        get(8'h05, 32'h0000_1fe9);
        init_fail = 4'h1;
        sensor_unresp = 3'h2;
        get(8'h05, 32'h0000_1429);
        do_cmd(8'h07, 32'h0, 8'h00, 32'h0);
        check(stream_on, 32'h1);
        do_cmd(8'h05, 32'h0, 8'h01, 32'h0);
        do_cmd(8'h04, 32'h0, 8'h01, 32'h0);
        do_cmd(8'h07, 32'h0, 8'h01, 32'h0);
        do_cmd(8'h0b, 32'h5, 8'h01, 32'h0);
        do_cmd(8'h06, 32'h0, 8'h00, 32'h0);
        check(stream_on, 32'h0);
        get(8'h04, cfg_exp);
        upload(8'h02, 0, 1'b0, 8'h00);
        upload(8'h02, 2, 1'b1, 8'h01);
        upload(8'h03, 1, 1'b0, 8'h00);
        get(8'h05, 32'h0000_1429);
        check(img_count, 32'd768);
        report_and_stop();
    end
endmodule
